// *** inc/irq_ctrl_consts.svh ***
`ifndef IRQ_CTRL_CONSTS_SVH
`define IRQ_CTRL_CONSTS_SVH

// ==========================================================
// Register offsets
`define ADDR_PRIMARY_IRQ_ENABLE  8'ha8
`define ADDR_PRIMARY_IRQ_LEVEL   8'hb8
`define ADDR_AUX_CONTROL         8'hd8
`define ADDR_EXTENDED_IRQ_ENABLE 8'he8
`define ADDR_EXTENDED_IRQ_LEVEL  8'hf8

// ==========================================================
// Field positions
`define BIT_GLOBAL_IRQ_GATE      7
`define BIT_SERIAL1_DOUBLE_RATE  7
`define BIT_AUX_CTRL_ONE         6
`define BIT_AUX_GROUP_ENABLE     5
`define BIT_AUX_PENDING_FLAG     4
`define BIT_WATCHDOG_PENDING     3

// ==========================================================
// Reset values and fixed read bits
`define RESET_BYTE               8'h00
`define EXT_UPPER_ONES           3'h7

// ==========================================================
// Vector layout
`define VECTOR_BASE              16'h0003
`define VECTOR_SLOT_SHIFT        3
`define VECTOR_AUX               16'h0033
`define WATCHDOG_INDEX           12
`define AUTO_CLEAR_MASK          13'h0f0f

`endif

// *** inc/irq_ctrl_pkg.sv ***
package irq_ctrl_pkg;

    // Priority level of a request
    typedef enum logic [1:0] {
        LEVEL_LOW,
        LEVEL_HIGH,
        LEVEL_AUX
    } level_type;

    // Entry and return sequencing
    typedef enum logic [2:0] {
        SEQ_IDLE,
        SEQ_PUSH_HI,
        SEQ_VECTOR,
        SEQ_POP_HI,
        SEQ_POP_LO,
        SEQ_LOAD
    } seq_state_type;

endpackage

// *** tb/core_side_model.sv ***
`timescale 1ns/1ps
module core_side_model (
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic        push_valid,
    input  wire logic [7:0]  push_data,
    input  wire logic        pop_req,
    input  wire logic [12:0] flag_clear,
    input  wire logic [12:0] flag_raise,
    input  wire logic [12:0] flag_drop,
    output logic [7:0]       stack_rdata,
    output logic [12:0]      src_flag
);
    // ==========================================================
    // Return stack and flag sources
    logic [7:0] stack_mem [0:15];
    logic [3:0] stack_ptr;

    // Pops return the top byte a cycle later; idle data keeps toggling so stale bytes never pass
    always_ff @(posedge clk) begin
        if (srst) begin
            stack_ptr   <= 4'h0;
            stack_rdata <= 8'h5a;
        end else if (push_valid) begin
            stack_mem[stack_ptr] <= push_data;
            stack_ptr            <= stack_ptr + 4'h1;
            stack_rdata          <= ~stack_rdata;
        end else if (pop_req) begin
            stack_rdata <= stack_mem[stack_ptr - 4'h1];
            stack_ptr   <= stack_ptr - 4'h1;
        end else begin
            stack_rdata <= ~stack_rdata;
        end
    end

    // Flags stay set until hardware or software clears them
    always_ff @(posedge clk) begin
        if (srst) begin
            src_flag <= 13'h0000;
        end else begin
            src_flag <= (src_flag & ~flag_clear & ~flag_drop) | flag_raise;
        end
    end
endmodule // core_side_model

// *** tb/three_level_interrupt_controller_tb_top.sv ***
`timescale 1ns/1ps
module three_level_interrupt_controller_tb_top;
    // ==========================================================
    // Signals
    logic        clk = 1'b0;
    logic        srst = 1'b1;
    logic [7:0]  sfr_addr = 8'h00;
    logic        sfr_wr = 1'b0;
    logic        sfr_rd = 1'b0;
    logic [7:0]  sfr_wdata = 8'h00;
    logic [7:0]  sfr_rdata;
    logic [12:0] src_flag;
    logic        aux_flag = 1'b0;
    logic        instr_end = 1'b0;
    logic        return_from_handler = 1'b0;
    logic [15:0] pc_now = 16'h0000;
    logic [7:0]  stack_rdata;
    logic        push_valid;
    logic [7:0]  push_data;
    logic        pop_req;
    logic        vector_valid;
    logic [15:0] vector_addr;
    logic        pc_load;
    logic [15:0] pc_value;
    logic [12:0] flag_clear;
    logic        seq_busy;
    logic [2:0]  in_service;
    logic [12:0] flag_raise = 13'h0000;
    logic [12:0] flag_drop = 13'h0000;
    int          n_mismatch = 0;
    int          checks = 0;

    // 250 MHz core clock
    always #2 clk = ~clk;

    three_level_interrupt_controller uut (.clk(clk), .srst(srst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
        .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .src_flag(src_flag),
        .aux_flag(aux_flag), .instr_end(instr_end), .return_from_handler(return_from_handler),
        .pc_now(pc_now), .stack_rdata(stack_rdata), .push_valid(push_valid), .push_data(push_data),
        .pop_req(pop_req), .vector_valid(vector_valid), .vector_addr(vector_addr), .pc_load(pc_load),
        .pc_value(pc_value), .flag_clear(flag_clear), .seq_busy(seq_busy), .in_service(in_service));

    core_side_model far_side (.clk(clk), .srst(srst), .push_valid(push_valid), .push_data(push_data),
        .pop_req(pop_req), .flag_clear(flag_clear), .flag_raise(flag_raise), .flag_drop(flag_drop),
        .stack_rdata(stack_rdata), .src_flag(src_flag));

    // ==========================================================
    // Shared tasks
    task automatic final_report();
        $display("Mismatches %0d, comparisons %0d", n_mismatch, checks);
        if (n_mismatch == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Bounded wait step; a hang ends the run
    task automatic step(inout int n);
        if (n == 20) begin
            n_mismatch++;
            final_report();
        end else begin
            n++;
            @(negedge clk);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        sfr_addr  = a;
        sfr_wdata = d;
        sfr_wr    = 1'b1;
        @(negedge clk);
        sfr_wr = 1'b0;
        @(negedge clk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        sfr_addr = a;
        sfr_rd   = 1'b1;
        @(negedge clk);
        sfr_rd = 1'b0;
        @(negedge clk);
        chk({8'h00, sfr_rdata}, {8'h00, exp});
    endtask

    task automatic flags(input logic [12:0] up, input logic [12:0] down);
        flag_raise = up;
        flag_drop  = down;
        @(negedge clk);
        flag_raise = 13'h0000;
        flag_drop  = 13'h0000;
        @(negedge clk);
    endtask

    // Poll once; checks pushed PC pair, vector, auto-clear and level bits
    task automatic enter(input logic [15:0] pc, input logic [15:0] vec, input logic [12:0] clr,
                         input logic [2:0] isv);
        logic [7:0] lo;
        logic [7:0] hi;
        int         n;
        lo = 8'hxx;
        hi = 8'hxx;
        n = 0;
        pc_now    = pc;
        instr_end = 1'b1;
        @(negedge clk);
        instr_end = 1'b0;
        while (vector_valid !== 1'b1) begin
            if (push_valid === 1'b1) begin
                chk({15'h0, seq_busy}, 16'h0001);
                lo = hi;
                hi = push_data;
            end
            step(n);
        end
        chk({hi, lo}, pc);
        chk(vector_addr, vec);
        chk({3'h0, flag_clear}, {3'h0, clr});
        chk({13'h0, in_service}, {13'h0, isv});
    endtask

    // Poll that must not start an entry
    task automatic no_entry();
        logic seen;
        seen = 1'b0;
        instr_end = 1'b1;
        @(negedge clk);
        instr_end = 1'b0;
        repeat (6) begin
            seen = seen | push_valid | vector_valid;
            @(negedge clk);
        end
        chk({15'h0, seen}, 16'h0000);
    endtask

    task automatic leave(input logic [15:0] pc, input logic [2:0] isv);
        int n;
        n = 0;
        return_from_handler = 1'b1;
        @(negedge clk);
        return_from_handler = 1'b0;
        while (pc_load !== 1'b1) begin
            step(n);
        end
        chk(pc_value, pc);
        chk({13'h0, in_service}, {13'h0, isv});
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_reset();
        rd(8'ha8, 8'h00);
        rd(8'hb8, 8'h00);
        rd(8'hd8, 8'h40);
        rd(8'he8, 8'he0);
        rd(8'hf8, 8'he0);
        flags(13'h0002, 13'h0000);
        no_entry();
        flags(13'h0000, 13'h0002);
    endtask

    // Fixed bits, writable fields and an unmapped address
    task automatic t_regs();
        wr(8'h99, 8'h55);
        rd(8'h99, 8'h00);
        wr(8'ha8, 8'hff);
        rd(8'ha8, 8'hff);
        wr(8'hb8, 8'hff);
        rd(8'hb8, 8'h1f);
        wr(8'hd8, 8'hff);
        rd(8'hd8, 8'he0);
        wr(8'he8, 8'hff);
        rd(8'he8, 8'hff);
        wr(8'hf8, 8'hff);
        rd(8'hf8, 8'hff);
        wr(8'ha8, 8'h00);
        wr(8'hd8, 8'h00);
        wr(8'he8, 8'h00);
        wr(8'hb8, 8'h00);
        wr(8'hf8, 8'h00);
    endtask

    // Source enable alone is not enough until the gate opens
    task automatic t_gate();
        flags(13'h0008, 13'h0000);
        wr(8'ha8, 8'h08);
        no_entry();
        wr(8'ha8, 8'h88);
        enter(16'h1234, 16'h001b, 13'h0008, 3'b001);
        leave(16'h1234, 3'b000);
    endtask

    // Same level: polling order, then the loser waits for the return
    task automatic t_order();
        wr(8'ha8, 8'h91);
        flags(13'h0011, 13'h0000);
        enter(16'ha001, 16'h0003, 13'h0001, 3'b001);
        no_entry();
        leave(16'ha001, 3'b000);
        enter(16'ha002, 16'h0023, 13'h0000, 3'b001);
        leave(16'ha002, 3'b000);
        flags(13'h0000, 13'h0010);
    endtask

    // Nested handlers across all three levels
    task automatic t_preempt();
        wr(8'ha8, 8'h96);
        wr(8'hb8, 8'h14);
        wr(8'hd8, 8'h20);
        flags(13'h0002, 13'h0000);
        enter(16'hb001, 16'h000b, 13'h0002, 3'b001);
        flags(13'h0010, 13'h0000);
        enter(16'hb002, 16'h0023, 13'h0000, 3'b011);
        flags(13'h0004, 13'h0000);
        no_entry();
        aux_flag = 1'b1;
        enter(16'hb003, 16'h0033, 13'h0000, 3'b111);
        no_entry();
        aux_flag = 1'b0;
        leave(16'hb003, 3'b011);
        leave(16'hb002, 3'b001);
        enter(16'hb004, 16'h0013, 13'h0004, 3'b011);
        leave(16'hb004, 3'b001);
        leave(16'hb001, 3'b000);
        flags(13'h0000, 13'h0010);
        wr(8'hb8, 8'h00);
    endtask

    // Aux group works with the global gate closed; pin 0 does not
    task automatic t_aux();
        wr(8'ha8, 8'h01);
        wr(8'hd8, 8'h20);
        flags(13'h0001, 13'h0000);
        aux_flag = 1'b1;
        rd(8'hd8, 8'h70);
        enter(16'hc001, 16'h0033, 13'h0000, 3'b100);
        aux_flag = 1'b0;
        leave(16'hc001, 3'b000);
        no_entry();
        wr(8'ha8, 8'h81);
        enter(16'hc002, 16'h0003, 13'h0001, 3'b001);
        leave(16'hc002, 3'b000);
        wr(8'hd8, 8'h00);
    endtask

    // Extended sources: pins 2 to 5 and the watchdog
    task automatic t_ext();
        logic [12:0] bits;
        logic [15:0] vec;
        wr(8'ha8, 8'h80);
        wr(8'he8, 8'h1f);
        for (int i = 8; i <= 12; i++) begin
            bits = 13'h0001 << i;
            vec  = 16'h0043 + 16'(8 * (i - 8));
            flags(bits, 13'h0000);
            if (i == 12) begin
                rd(8'hd8, 8'h48);
            end
            enter(16'hd000 + 16'(i), vec, (i == 12) ? 13'h0000 : bits, 3'b001);
            leave(16'hd000 + 16'(i), 3'b000);
            flags(13'h0000, bits);
        end
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        repeat (20) @(negedge clk);
        srst = 1'b0;
        t_reset();
        t_regs();
        t_gate();
        t_order();
        t_preempt();
        t_aux();
        t_ext();
        final_report();
    end
endmodule // three_level_interrupt_controller_tb_top

// *** verilog/irq_in_service.sv ***
`timescale 1ns/1ps
module irq_in_service
    import irq_ctrl_pkg::*;
(
    input  wire logic      clk,
    input  wire logic      srst,
    input  wire logic      set_pulse,
    input  level_type      set_level,
    input  wire logic      clear_pulse,
    output logic [2:0]     in_service
);

    // ==========================================================
    // Return always closes the most urgent active level
    wire logic [2:0] next_clear = in_service[2] ? 3'h4 : (in_service[1] ? 3'h2 : (in_service[0] ? 3'h1 : 3'h0));
    wire logic [2:0] next_set   = 3'(1) << set_level;

    always_ff @(posedge clk) begin
        if (srst) begin
            in_service <= 3'h0;
        end else if (set_pulse) begin
            in_service <= in_service | next_set;
        end else if (clear_pulse) begin
            in_service <= in_service & ~next_clear;
        end
    end

endmodule // irq_in_service

// *** verilog/irq_priority_picker.sv ***
`timescale 1ns/1ps
module irq_priority_picker
    import irq_ctrl_pkg::*;
#(
    parameter int NUM_SRC = 13
) (
    input  wire logic [NUM_SRC-1:0] req,
    input  wire logic [NUM_SRC-1:0] level_sel,
    input  wire logic               aux_req,
    output logic                    win_valid,
    output logic [3:0]              win_index,
    output level_type               win_level
);

    // ==========================================================
    // Lowest set index, natural polling order
    function automatic logic [3:0] first_set(input logic [NUM_SRC-1:0] v);
        logic [3:0] r;
        r = 4'h0;
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = 4'(i);
            end
        end
        return r;
    endfunction

    wire logic [NUM_SRC-1:0] high_req = req & level_sel;
    wire logic [NUM_SRC-1:0] low_req  = req & ~level_sel;

    // ==========================================================
    // Aux beats high beats low; index order inside a level
    always_comb begin
        win_valid = 1'b1;
        win_index = 4'h0;
        win_level = LEVEL_LOW;
        if (aux_req) begin
            win_level = LEVEL_AUX;
        end else if (|high_req) begin
            win_level = LEVEL_HIGH;
            win_index = first_set(high_req);
        end else if (|low_req) begin
            win_index = first_set(low_req);
        end else begin
            win_valid = 1'b0;
        end
    end

endmodule // irq_priority_picker

// *** verilog/three_level_interrupt_controller.sv ***
`timescale 1ns/1ps
`include "irq_ctrl_consts.svh"
module three_level_interrupt_controller
    import irq_ctrl_pkg::*;
#(
    parameter int NUM_SRC = 13
) (
    input  wire logic               clk,
    input  wire logic               srst,
    input  wire logic [7:0]         sfr_addr,
    input  wire logic               sfr_wr,
    input  wire logic               sfr_rd,
    input  wire logic [7:0]         sfr_wdata,
    output logic [7:0]              sfr_rdata,
    input  wire logic [NUM_SRC-1:0] src_flag,
    input  wire logic               aux_flag,
    input  wire logic               instr_end,
    input  wire logic               return_from_handler,
    input  wire logic [15:0]        pc_now,
    input  wire logic [7:0]         stack_rdata,
    output logic                    push_valid,
    output logic [7:0]              push_data,
    output logic                    pop_req,
    output logic                    vector_valid,
    output logic [15:0]             vector_addr,
    output logic                    pc_load,
    output logic [15:0]             pc_value,
    output logic [NUM_SRC-1:0]      flag_clear,
    output logic                    seq_busy,
    output logic [2:0]              in_service
);

    // ==========================================================
    // Software visible registers
    logic [7:0]    primary_irq_enable;
    logic [4:0]    primary_irq_level;
    logic          serial1_double_rate;
    logic          aux_group_enable;
    logic [4:0]    extended_irq_enable;
    logic [4:0]    extended_irq_level;

    // ==========================================================
    // Sequencer state
    seq_state_type state;
    logic [7:0]    pc_hold;
    logic [3:0]    taken_index;
    level_type     taken_level;

    // Write strobes decoded once
    wire logic wr_pen  = sfr_wr && (sfr_addr == `ADDR_PRIMARY_IRQ_ENABLE);
    wire logic wr_plv  = sfr_wr && (sfr_addr == `ADDR_PRIMARY_IRQ_LEVEL);
    wire logic wr_aux  = sfr_wr && (sfr_addr == `ADDR_AUX_CONTROL);
    wire logic wr_xen  = sfr_wr && (sfr_addr == `ADDR_EXTENDED_IRQ_ENABLE);
    wire logic wr_xlv  = sfr_wr && (sfr_addr == `ADDR_EXTENDED_IRQ_LEVEL);

    // ==========================================================
    // Register writes; pending flags are not writable here, so
    // software cannot fake an aux event
    always_ff @(posedge clk) begin
        if (srst) begin
            primary_irq_enable  <= `RESET_BYTE;
            primary_irq_level   <= 5'h00;
            serial1_double_rate <= 1'b0;
            aux_group_enable    <= 1'b0;
            extended_irq_enable <= 5'h00;
            extended_irq_level  <= 5'h00;
        end else begin
            if (wr_pen) begin
                primary_irq_enable <= sfr_wdata;
            end
            if (wr_plv) begin
                primary_irq_level <= sfr_wdata[4:0];
            end
            if (wr_aux) begin
                serial1_double_rate <= sfr_wdata[`BIT_SERIAL1_DOUBLE_RATE];
                aux_group_enable    <= sfr_wdata[`BIT_AUX_GROUP_ENABLE];
            end
            if (wr_xen) begin
                extended_irq_enable <= sfr_wdata[4:0];
            end
            if (wr_xlv) begin
                extended_irq_level <= sfr_wdata[4:0];
            end
        end
    end

    // ==========================================================
    // Read views; undefined primary level bits read zero
    wire logic [7:0] view_aux = {serial1_double_rate, 1'b1, aux_group_enable, aux_flag,
                                 src_flag[`WATCHDOG_INDEX], 3'h0};
    wire logic [7:0] view_xen = {`EXT_UPPER_ONES, extended_irq_enable};
    wire logic [7:0] view_xlv = {`EXT_UPPER_ONES, extended_irq_level};
    wire logic [7:0] view_plv = {3'h0, primary_irq_level};

    wire logic [7:0] next_rdata =
        (sfr_addr == `ADDR_PRIMARY_IRQ_ENABLE)  ? primary_irq_enable :
        (sfr_addr == `ADDR_PRIMARY_IRQ_LEVEL)   ? view_plv :
        (sfr_addr == `ADDR_AUX_CONTROL)         ? view_aux :
        (sfr_addr == `ADDR_EXTENDED_IRQ_ENABLE) ? view_xen :
        (sfr_addr == `ADDR_EXTENDED_IRQ_LEVEL)  ? view_xlv : 8'h00;

    // Read data registered; holds until the next read
    always_ff @(posedge clk) begin
        if (srst) begin
            sfr_rdata <= 8'h00;
        end else if (sfr_rd) begin
            sfr_rdata <= next_rdata;
        end
    end

    // ==========================================================
    // Request qualification; flags are levels from the sources,
    // so a masked request simply waits in its source
    wire logic                global_irq_gate = primary_irq_enable[`BIT_GLOBAL_IRQ_GATE];
    // Slot 6 belongs to the aux vector at 33, so no flag source uses it;
    // serial 1 sits in slot 7, and timer 2 and serial 1 stay at low level
    wire logic [NUM_SRC-1:0]  src_enable = {extended_irq_enable, primary_irq_enable[6], 1'b0,
                                            primary_irq_enable[5:0]};
    wire logic [NUM_SRC-1:0]  src_level  = {extended_irq_level, 3'h0, primary_irq_level};
    wire logic                allow_aux  = !in_service[2];
    wire logic                allow_high = !in_service[2] && !in_service[1];
    wire logic                allow_low  = (in_service == 3'h0);
    wire logic [NUM_SRC-1:0]  level_ok   = (src_level & {NUM_SRC{allow_high}}) |
                                           (~src_level & {NUM_SRC{allow_low}});
    wire logic [NUM_SRC-1:0]  qual_req   = src_flag & src_enable & {NUM_SRC{global_irq_gate}} & level_ok;
    wire logic                qual_aux   = aux_flag && aux_group_enable && allow_aux;

    logic          win_valid;
    logic [3:0]    win_index;
    level_type     win_level;

    // Fixed order arbitration inside each level
    irq_priority_picker #(
        .NUM_SRC   (NUM_SRC)
    ) u_picker (
        .req       (qual_req),
        .level_sel (src_level),
        .aux_req   (qual_aux),
        .win_valid (win_valid),
        .win_index (win_index),
        .win_level (win_level)
    );

    // ==========================================================
    // Vector of a source: eight-byte slots from 03, aux at 33
    function automatic logic [15:0] vector_of(input logic [3:0] idx, input level_type lvl);
        if (lvl == LEVEL_AUX) begin
            return `VECTOR_AUX;
        end
        return `VECTOR_BASE + (16'(idx) << `VECTOR_SLOT_SHIFT);
    endfunction

    wire logic take_irq   = (state == SEQ_IDLE) && instr_end && !return_from_handler && win_valid;
    wire logic take_ret   = (state == SEQ_IDLE) && return_from_handler;
    wire logic isv_set    = (state == SEQ_VECTOR);
    wire logic isv_clear  = (state == SEQ_LOAD);
    wire logic [NUM_SRC-1:0] clear_onehot = NUM_SRC'(1) << taken_index;

    // Level bookkeeping for preemption
    irq_in_service u_in_service (
        .clk         (clk),
        .srst        (srst),
        .set_pulse   (isv_set),
        .set_level   (taken_level),
        .clear_pulse (isv_clear),
        .in_service  (in_service)
    );

    // ==========================================================
    // Entry: push low, push high, vector. Return: pop high, pop
    // low, reload. A return in the same cycle as a poll wins,
    // since the handler must close before anything new enters.
    always_ff @(posedge clk) begin
        if (srst) begin
            state        <= SEQ_IDLE;
            pc_hold      <= 8'h00;
            taken_index  <= 4'h0;
            taken_level  <= LEVEL_LOW;
            push_valid   <= 1'b0;
            push_data    <= 8'h00;
            pop_req      <= 1'b0;
            vector_valid <= 1'b0;
            vector_addr  <= 16'h0000;
            pc_load      <= 1'b0;
            pc_value     <= 16'h0000;
            flag_clear   <= '0;
            seq_busy     <= 1'b0;
        end else begin
            vector_valid <= 1'b0;
            pc_load      <= 1'b0;
            flag_clear   <= '0;
            case (state)
                SEQ_IDLE: begin
                    if (take_ret) begin
                        pop_req  <= 1'b1;
                        seq_busy <= 1'b1;
                        state    <= SEQ_POP_HI;
                    end else if (take_irq) begin
                        push_valid  <= 1'b1;
                        push_data   <= pc_now[7:0];
                        pc_hold     <= pc_now[15:8];
                        taken_index <= win_index;
                        taken_level <= win_level;
                        seq_busy    <= 1'b1;
                        state       <= SEQ_PUSH_HI;
                    end
                end
                SEQ_PUSH_HI: begin
                    push_data <= pc_hold;
                    state     <= SEQ_VECTOR;
                end
                SEQ_VECTOR: begin
                    push_valid   <= 1'b0;
                    vector_valid <= 1'b1;
                    vector_addr  <= vector_of(taken_index, taken_level);
                    if (taken_level != LEVEL_AUX) begin
                        flag_clear <= clear_onehot & `AUTO_CLEAR_MASK;
                    end
                    seq_busy <= 1'b0;
                    state    <= SEQ_IDLE;
                end
                SEQ_POP_HI: begin
                    state <= SEQ_POP_LO;
                end
                SEQ_POP_LO: begin
                    // Exactly two pops; a third would eat the outer frame
                    pop_req        <= 1'b0;
                    pc_value[15:8] <= stack_rdata;
                    state          <= SEQ_LOAD;
                end
                SEQ_LOAD: begin
                    pc_value[7:0] <= stack_rdata;
                    pc_load       <= 1'b1;
                    seq_busy      <= 1'b0;
                    state         <= SEQ_IDLE;
                end
                default: begin
                    state <= SEQ_IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // Checks
    chk_vector_gate: assert property (@(posedge clk) disable iff (srst)
        vector_valid && vector_addr != `VECTOR_AUX |-> $past(global_irq_gate, 3))
        else $error("non-aux vector taken while gate was closed");

    chk_aux_group_gate: assert property (@(posedge clk) disable iff (srst)
        vector_valid && vector_addr == `VECTOR_AUX |-> $past(aux_group_enable, 3))
        else $error("aux vector taken while group disabled");

    chk_push_order: assert property (@(posedge clk) disable iff (srst)
        take_irq |=> push_valid && push_data == $past(pc_now[7:0])
                     ##1 push_valid && push_data == $past(pc_now[15:8], 2)
                     ##1 vector_valid)
        else $error("push order or byte wrong");

    chk_vector_value: assert property (@(posedge clk) disable iff (srst)
        take_irq && win_level != LEVEL_AUX |-> ##3 vector_addr == 16'h0003 + 16'($past(win_index, 3)) * 16'h0008)
        else $error("vector address wrong");

    chk_timer1_vector: assert property (@(posedge clk) disable iff (srst)
        take_irq && win_level != LEVEL_AUX && win_index == 4'h3 |-> ##3 vector_valid && vector_addr == 16'h001b)
        else $error("timer 1 not vectored to its handler");

    chk_flag_autoclear: assert property (@(posedge clk) disable iff (srst)
        vector_valid && vector_addr == 16'h000b |-> flag_clear == 13'h0002)
        else $error("timer 0 flag not cleared on vector");

    chk_aux_no_preempt: assert property (@(posedge clk) disable iff (srst)
        in_service[2] |-> !take_irq)
        else $error("request taken during aux handler");

    chk_high_only_aux: assert property (@(posedge clk) disable iff (srst)
        in_service[1] && take_irq |-> win_level == LEVEL_AUX)
        else $error("non-aux preempted a high handler");

    chk_low_when_idle: assert property (@(posedge clk) disable iff (srst)
        take_irq && win_level == LEVEL_LOW |-> in_service == 3'h0)
        else $error("low request taken with a handler active");

    chk_pop_restore: assert property (@(posedge clk) disable iff (srst)
        take_ret ##1 pop_req ##1 pop_req |=> ##1 pc_load && pc_value == {$past(stack_rdata, 2), $past(stack_rdata)})
        else $error("return did not reload popped address");

    chk_ext_ones: assert property (@(posedge clk) disable iff (srst)
        $past(sfr_rd) && $past(sfr_addr) == `ADDR_EXTENDED_IRQ_ENABLE |-> sfr_rdata[7:5] == 3'h7)
        else $error("extended enable upper bits not one");

    cov_preempt_low: cover property (@(posedge clk) disable iff (srst)
        in_service[0] && take_irq && win_level == LEVEL_HIGH);

    cov_aux_entry: cover property (@(posedge clk) disable iff (srst)
        vector_valid && vector_addr == `VECTOR_AUX);

    cov_return: cover property (@(posedge clk) disable iff (srst) pc_load);

    cov_watchdog_entry: cover property (@(posedge clk) disable iff (srst)
        vector_valid && vector_addr == 16'h0063);

endmodule // three_level_interrupt_controller
